// File: src/flash_host.sv
// Host controller for a 64K x 16 sector flash with software protection.
// Assumes a single clock; flash data pins are external and asynchronous.
`include "flash_host_defs.svh"

module flash_host #(
  parameter logic [15:0] UNLK_A0 = 16'h5555,
  parameter logic [15:0] UNLK_A1 = 16'h2AAA,
  parameter logic [15:0] UNLK_A2 = 16'h5555,
  parameter logic [15:0] UNLK_D0 = 16'h00AA,
  parameter logic [15:0] UNLK_D1 = 16'h0055,
  parameter logic [15:0] UNLK_D2 = 16'h00A0,
  parameter logic [15:0] ERS_D2 = 16'h0080,
  parameter logic [15:0] ERS_D5 = 16'h0010,
  parameter int unsigned PWRUP_CYC = `FH_PWRUP_CYC,
  parameter int unsigned GAP_CYC = `FH_GAP_SAFE_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // User side
  input wire logic RD_REQ_I, // Single-word read
  input wire logic PROG_REQ_I, // Start a sector program
  input wire logic ERASE_REQ_I, // Whole-array erase
  input wire logic [15:0] ADDR_I, // Read address or sector base
  output logic WORD_REQ_O, // Asks for next load word
  input wire logic WORD_VALID_I, // Word supplied
  input wire logic [6:0] WORD_IDX_I, // Word within sector
  input wire logic WORD_LAST_I, // Last word of sector
  input wire logic [15:0] WORD_DATA_I,
  output logic [15:0] RD_DATA_O,
  output logic RD_DONE_O,
  output logic BUSY_O,
  output logic OP_DONE_O,
  // Flash pins
  output logic [15:0] FL_ADDR_O,
  output logic FL_CE_N_O,
  output logic FL_OE_N_O,
  output logic FL_WE_N_O,
  input wire logic [15:0] FL_DATA_I,
  output logic [15:0] FL_DATA_O,
  output logic FL_DATA_OE_O
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    flash_host_pkg::state_t st;
    flash_host_pkg::op_t op;
    logic [2:0] step; // Command write number
    logic [19:0] cnt; // General timer
    logic [15:0] addr;
    logic [8:0] sect; // Target sector, kept through the unlock writes
    logic [7:0] wlow; // Cycles the write strobe has been low
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] sync1; // First sync stage
    logic [15:0] sync2;
    logic [15:0] prev; // Previous poll read
    logic have_prev;
    logic last; // Last load word sent
    logic rd_done;
    logic op_done;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic doe;
  } reg_t;

  reg_t q, d;

  // Command address for a step of unlock or erase code
  function automatic logic [15:0] cmd_addr(input logic [2:0] s);
    unique case (s)
      3'h1, 3'h4: cmd_addr = UNLK_A1;
      3'h2: cmd_addr = UNLK_A2;
      default: cmd_addr = UNLK_A0;
    endcase
  endfunction : cmd_addr

  // Command data for a step
  function automatic logic [15:0] cmd_data(input logic [2:0] s,
                                           input logic ers);
    unique case (s)
      3'h0, 3'h3: cmd_data = UNLK_D0;
      3'h1, 3'h4: cmd_data = UNLK_D1;
      3'h2: cmd_data = ers ? ERS_D2 : UNLK_D2;
      default: cmd_data = ERS_D5;
    endcase
  endfunction : cmd_data

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;
    d.sync1 = FL_DATA_I;
    d.sync2 = q.sync1;
    d.rd_done = 1'b0;
    d.op_done = 1'b0;
    d.wlow = q.we_n ? 8'h00 : q.wlow + 8'h01; // Strobe width count
    unique case (q.st)
      flash_host_pkg::ST_PWRUP: begin
        // Hold off programming after power-up
        if (q.cnt == 20'(PWRUP_CYC)) begin
          d.st = flash_host_pkg::ST_IDLE;
        end else begin
          d.cnt = q.cnt + 20'h1;
        end
      end
      flash_host_pkg::ST_IDLE: begin
        d.cnt = '0;
        d.step = '0;
        d.last = 1'b0;
        d.have_prev = 1'b0;
        if (RD_REQ_I) begin
          d.op = flash_host_pkg::OP_READ;
          d.addr = ADDR_I;
          d.st = flash_host_pkg::ST_RLOW;
        end else if (PROG_REQ_I || ERASE_REQ_I) begin
          // Unlock code always first, whatever came before
          // No write ever goes out without it
          d.op = PROG_REQ_I ? flash_host_pkg::OP_UNLOCK
                            : flash_host_pkg::OP_ERASE;
          d.addr = ADDR_I;
          d.sect = ADDR_I[15:7]; // Sector number
          d.st = flash_host_pkg::ST_SETUP;
        end
      end
      flash_host_pkg::ST_SETUP: begin
        // Present address, gate high before strobe
        d.oe_n = 1'b1;
        d.doe = 1'b1;
        d.cnt = '0;
        if (q.op == flash_host_pkg::OP_LOAD) begin
          if (WORD_VALID_I) begin
            // Sector kept, word index low bits
            d.addr = {q.sect, WORD_IDX_I};
            d.wdata = WORD_DATA_I;
            d.last = WORD_LAST_I; // Short sector reads back ones
            d.st = flash_host_pkg::ST_LOW;
          end
        end else begin
          d.addr = cmd_addr(q.step);
          d.wdata = cmd_data(q.step, q.op == flash_host_pkg::OP_ERASE);
          d.st = flash_host_pkg::ST_LOW;
        end
      end
      flash_host_pkg::ST_LOW: begin
        // Chip select and write strobe low together; address taken here
        d.ce_n = 1'b0;
        d.we_n = 1'b0;
        d.cnt = q.cnt + 20'h1;
        if (q.cnt == 20'(`FH_STROBE_CYC)) begin
          // Rising strobe latches data
          d.we_n = 1'b1;
          d.cnt = '0;
          d.st = flash_host_pkg::ST_HIGH;
        end
      end
      flash_host_pkg::ST_HIGH: begin
        d.ce_n = 1'b1;
        d.cnt = q.cnt + 20'h1;
        if (q.cnt == 20'(`FH_STROBE_CYC)) begin
          d.cnt = '0;
          if (q.op != flash_host_pkg::OP_LOAD) begin
            d.step = q.step + 3'h1; // Counts command writes only
          end
          d.st = flash_host_pkg::ST_SETUP;
          if (q.op == flash_host_pkg::OP_UNLOCK && q.step == 3'h2) begin
            d.op = flash_host_pkg::OP_LOAD;
          end else if (q.op == flash_host_pkg::OP_ERASE &&
                       q.step == 3'h5) begin
            d.st = flash_host_pkg::ST_RLOW;
          end else if (q.op == flash_host_pkg::OP_LOAD && q.last) begin
            // Stop loading; the gap starts the program
            d.doe = 1'b0;
            d.st = flash_host_pkg::ST_RLOW;
          end
        end
      end
      flash_host_pkg::ST_RLOW: begin
        // Read cycle: select and gate low, strobe high
        d.doe = 1'b0;
        d.we_n = 1'b1;
        d.ce_n = 1'b0;
        d.oe_n = 1'b0;
        d.cnt = q.cnt + 20'h1;
        if (q.cnt == 20'(`FH_STROBE_CYC)) begin
          d.cnt = '0;
          d.ce_n = 1'b1;
          d.oe_n = 1'b1; // Flash floats its pins
          d.rdata = q.sync2;
          d.st = (q.op == flash_host_pkg::OP_READ)
                 ? flash_host_pkg::ST_RDONE : flash_host_pkg::ST_POLL;
        end
      end
      flash_host_pkg::ST_RDONE: begin
        d.rd_done = 1'b1;
        d.st = flash_host_pkg::ST_IDLE;
      end
      flash_host_pkg::ST_POLL: begin
        // Busy while bits 6/14 toggle
        d.prev = q.rdata;
        d.have_prev = 1'b1;
        if (q.have_prev && q.rdata[`FH_TOGGLE_LO] == q.prev[`FH_TOGGLE_LO]
            && q.rdata[`FH_TOGGLE_HI] == q.prev[`FH_TOGGLE_HI]
            && (q.op != flash_host_pkg::OP_LOAD ||
                (q.rdata[`FH_POLL_LO] == q.wdata[`FH_POLL_LO] &&
                 q.rdata[`FH_POLL_HI] == q.wdata[`FH_POLL_HI]))) begin
          d.st = flash_host_pkg::ST_DONE;
        end else begin
          d.st = flash_host_pkg::ST_RLOW;
        end
      end
      flash_host_pkg::ST_DONE: begin
        d.op_done = 1'b1;
        d.st = flash_host_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      q <= '0;
      q.st <= flash_host_pkg::ST_PWRUP;
      q.op <= flash_host_pkg::OP_READ;
      q.ce_n <= 1'b1;
      q.oe_n <= 1'b1;
      q.we_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign FL_ADDR_O = q.addr;
  assign FL_DATA_O = q.wdata;
  assign FL_DATA_OE_O = q.doe;
  assign FL_CE_N_O = q.ce_n;
  assign FL_OE_N_O = q.oe_n;
  assign FL_WE_N_O = q.we_n;
  assign RD_DATA_O = q.rdata;
  assign RD_DONE_O = q.rd_done;
  assign OP_DONE_O = q.op_done;
  assign BUSY_O = (q.st != flash_host_pkg::ST_IDLE);
  assign WORD_REQ_O = (q.st == flash_host_pkg::ST_SETUP) &&
                      (q.op == flash_host_pkg::OP_LOAD);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_no_write_with_gate;
    @(posedge REF_CLK_I) disable iff (RST_I)
      !FL_WE_N_O |-> FL_OE_N_O && !FL_CE_N_O && FL_DATA_OE_O;
  endproperty
  a_no_write_with_gate: assert property (p_no_write_with_gate)
    else $error("Write strobe low with gate low or select high");

  property p_read_no_drive;
    @(posedge REF_CLK_I) disable iff (RST_I)
      !FL_OE_N_O |-> !FL_DATA_OE_O && FL_WE_N_O;
  endproperty
  a_read_no_drive: assert property (p_read_no_drive)
    else $error("Host drives data while flash gate low");

  property p_pwrup_no_prog;
    @(posedge REF_CLK_I) disable iff (RST_I)
      q.st == flash_host_pkg::ST_PWRUP |-> FL_WE_N_O;
  endproperty
  a_pwrup_no_prog: assert property (p_pwrup_no_prog)
    else $error("Write during power-up wait");

  property p_sector_fixed;
    @(posedge REF_CLK_I) disable iff (RST_I)
      $fell(FL_WE_N_O) && q.op == flash_host_pkg::OP_LOAD
      |-> FL_ADDR_O[15:7] == q.sect;
  endproperty
  a_sector_fixed: assert property (p_sector_fixed)
    else $error("Sector number moved during load");

  property p_strobe_width;
    @(posedge REF_CLK_I) disable iff (RST_I)
      $rose(FL_WE_N_O) |-> q.wlow == `FH_STROBE_CYC;
  endproperty
  a_strobe_width: assert property (p_strobe_width)
    else $error("Write strobe width wrong");

  property p_addr_stable_low;
    @(posedge REF_CLK_I) disable iff (RST_I)
      !FL_WE_N_O && !$past(FL_WE_N_O) |-> $stable(FL_ADDR_O) &&
      $stable(FL_DATA_O);
  endproperty
  a_addr_stable_low: assert property (p_addr_stable_low)
    else $error("Address or data changed while strobe low");

  property p_gap_bound;
    @(posedge REF_CLK_I) disable iff (RST_I)
      $rose(FL_WE_N_O) && q.op == flash_host_pkg::OP_LOAD && !q.last
      |-> ##[1:60] (WORD_REQ_O || !FL_WE_N_O);
  endproperty
  a_gap_bound: assert property (p_gap_bound)
    else $error("Next word not asked for promptly");

  property p_unlock_first;
    @(posedge REF_CLK_I) disable iff (RST_I)
      WORD_REQ_O |-> q.step >= 3'h3;
  endproperty
  a_unlock_first: assert property (p_unlock_first)
    else $error("Load before three unlock writes");

endmodule : flash_host

// File: src/flash_host_defs.svh
// Constants for the sector flash host controller.
// Assumes a 100 MHz clock and a 16-bit asynchronous flash on the pins.
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH
// Strobe low and high widths in clock cycles
`define FH_STROBE_CYC 8'h0A
// Load gap limit, microseconds as printed, and a safe margin below it
`define FH_LOAD_GAP_US 150
`define FH_GAP_SAFE_CYC ((`FH_LOAD_GAP_US * 100) / 2)
// Power-on wait before any program, milliseconds
`define FH_PWRUP_MS 10
`define FH_PWRUP_CYC (`FH_PWRUP_MS * 100000)
// Words per sector
`define FH_SECTOR_WORDS 8'h80
// Polling bits
`define FH_POLL_HI 15
`define FH_POLL_LO 7
`define FH_TOGGLE_HI 14
`define FH_TOGGLE_LO 6
`endif

// File: src/flash_host_pkg.sv
// Types for the sector flash host controller.
// Assumes the constants header is included by the design file.
package flash_host_pkg;
  // Controller states, one-hot
  typedef enum logic [8:0] {
    ST_PWRUP = 9'h001,
    ST_IDLE = 9'h002,
    ST_SETUP = 9'h004,
    ST_LOW = 9'h008,
    ST_HIGH = 9'h010,
    ST_RLOW = 9'h020,
    ST_RDONE = 9'h040,
    ST_POLL = 9'h080,
    ST_DONE = 9'h100
  } state_t;
  // What the current bus cycle is for
  typedef enum logic [3:0] {
    OP_READ = 4'h1,
    OP_UNLOCK = 4'h2,
    OP_LOAD = 4'h4,
    OP_ERASE = 4'h8
  } op_t;
endpackage : flash_host_pkg

// File: test/flash_dev_model.sv
// Behavioural model of the 64K x 16 sector flash as seen at its pins.
// Assumes strobes from a clocked host; times in ns; the part has no reset.
module flash_dev_model #(
  parameter logic [15:0] A0 = 16'h5555, // Unlock addresses, arbitrary
  parameter logic [15:0] A1 = 16'h2AAA,
  parameter logic [15:0] D0 = 16'h00AA, // Command data, arbitrary
  parameter logic [15:0] D1 = 16'h0055,
  parameter logic [15:0] D2 = 16'h00A0,
  parameter logic [15:0] E2 = 16'h0080,
  parameter logic [15:0] E5 = 16'h0010,
  parameter int GAP_NS = 150000, // Load gap limit
  parameter int PROG_NS = 20000, // Shortened program time
  parameter int PWR_NS = 100 // Shortened power-on delay
) (
  input wire logic [15:0] addr_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:65535]; // 512 sectors of 128 words
  logic [15:0] lat [0:127]; // Load latches
  logic [127:0] got = '0; // Words loaded this period
  logic [15:0] a_q = 16'h0000; // Latched address
  logic [15:0] w_q = 16'hFFFF; // Last loaded word
  logic [15:0] rel_q = 16'h0000; // Released bus pattern
  logic loading = 1'h0;
  logic poll_q = 1'h0;
  logic tg = 1'h0;
  int step = 0; // Command progress, locked from power-on
  time t_q = 0;
  time end_q = 0;
  // Array starts erased
  initial for (int i = 0; i < 65536; i++) mem[i] = 16'hFFFF;
  wire wr_n = ce_n_i | we_n_i | ~oe_n_i; // Gate low blocks writes
  wire rd = !ce_n_i && !oe_n_i && we_n_i;
  wire [15:0] val = poll_q ?
    {~w_q[15], tg, w_q[13:8], ~w_q[7], tg, w_q[5:0]} : mem[addr_i];
  // Polling status while busy, array data else
  assign data_o = rd ? val : rel_q;

  function automatic logic [15:0] cmd(input int s);
    return (s == 2) ? E2 : ((s % 3) == 0) ? D0 : D1;
  endfunction : cmd

  ////////////////////////////////////////////////////////////////////////
  // Address at the later falling strobe
  always @(negedge wr_n) a_q = addr_i;
  // Data at the first rising strobe; commands and loads
  always @(posedge wr_n) begin
    if ($time >= PWR_NS && $time >= end_q) begin
      if (loading) begin // Any order within the sector
        lat[a_q[6:0]] = data_i;
        got[a_q[6:0]] = 1'h1;
        w_q = data_i;
        t_q = $time;
      end else if (step == 2 && a_q == A0 && data_i == D2) begin
        loading = 1'h1;
        step = 0;
        got = '0;
        t_q = $time;
      end else if (step == 5 && a_q == A0 && data_i == E5) begin
        for (int i = 0; i < 65536; i++) mem[i] = 16'hFFFF;
        w_q = 16'hFFFF;
        step = 0;
        end_q = $time + PROG_NS;
      end else if (a_q == ((step % 3) == 1 ? A1 : A0) && data_i == cmd(step))
        step++;
      else begin // Stray write: timer runs, nothing stored
        step = 0;
        end_q = $time + PROG_NS;
      end
    end
  end
  // Gap ends loading; sector erased, then written
  always #50 begin
    if (loading && $time - t_q > GAP_NS) begin
      for (int i = 0; i < 128; i++)
        mem[{a_q[15:7], i[6:0]}] = got[i] ? lat[i] : 16'hFFFF;
      loading = 1'h0;
      end_q = $time + PROG_NS;
    end
    poll_q = loading || $time < end_q;
  end
  // Toggle bits flip on each read
  always @(posedge rd) tg = ~tg;
  // Released bus shows the inverse of the last value
  always @(negedge rd) rel_q = ~val;
endmodule : flash_dev_model

// File: test/flash_host_tb_top.sv
// Self-checking bench for the sector flash host controller.
// Assumes the flash model in its own file and one 100 MHz clock.
module flash_host_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic rd_req = 1'h0;
  logic prog_req = 1'h0;
  logic ers_req = 1'h0;
  logic wvalid = 1'h0;
  logic wlast = 1'h0;
  logic [6:0] widx = 7'h00;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic word_req, rd_done, busy, op_done, ce_n, oe_n, we_n, fl_oe;
  logic [15:0] rd_data, fl_addr, fl_dout, dev_q;
  wire [15:0] bus = fl_oe ? fl_dout : dev_q; // Host drive wins when enabled
  int failures = 0;
  int num_checks = 0;
  always #5 clk = ~clk;

  flash_host #(.PWRUP_CYC(20)) flash_host_i (.REF_CLK_I(clk), .RST_I(rst),
    .RD_REQ_I(rd_req), .PROG_REQ_I(prog_req), .ERASE_REQ_I(ers_req),
    .ADDR_I(addr), .WORD_REQ_O(word_req), .WORD_VALID_I(wvalid),
    .WORD_IDX_I(widx), .WORD_LAST_I(wlast), .WORD_DATA_I(wdata),
    .RD_DATA_O(rd_data), .RD_DONE_O(rd_done), .BUSY_O(busy),
    .OP_DONE_O(op_done), .FL_ADDR_O(fl_addr), .FL_CE_N_O(ce_n),
    .FL_OE_N_O(oe_n), .FL_WE_N_O(we_n), .FL_DATA_I(bus),
    .FL_DATA_O(fl_dout), .FL_DATA_OE_O(fl_oe));
  flash_dev_model flash_dev_model_i (.addr_i(fl_addr), .ce_n_i(ce_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .data_i(bus), .data_o(dev_q));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  // Pin watch: no write with gate low, no bus fight
  always @(negedge clk) begin
    if (!we_n && !oe_n) chk("write gate", 16'h0001, 16'h0000);
    if (fl_oe && !ce_n && !oe_n) chk("bus fight", 16'h0000, 16'h0001);
  end

  // Word pattern per sector and index
  function automatic logic [15:0] wd(input logic [8:0] s, input logic [6:0] x);
    return {s[7:0] ^ 8'h5A, ~x[0], x};
  endfunction : wd

  task automatic idle_wait();
    for (int k = 0; k < 100 && busy !== 1'h0; k++) @(negedge clk);
    if (busy !== 1'h0) begin
      chk("idle", 16'h0000, {15'h0000, busy});
      test_done();
    end
  endtask : idle_wait

  task automatic wait_done(input string nm);
    int k;
    for (k = 0; k < 60000 && op_done !== 1'h1; k++) @(negedge clk);
    chk(nm, 16'h0001, {15'h0000, op_done});
    if (op_done !== 1'h1) test_done();
  endtask : wait_done

  // Present word i of n, forward or reversed index order
  task automatic set_word(input logic [8:0] s, input int i, input int n,
                          input bit rev);
    widx <= rev ? 7'(127 - i) : 7'(i);
    wdata <= wd(s, rev ? 7'(127 - i) : 7'(i));
    wvalid <= (i < n);
    wlast <= (i == n - 1);
  endtask : set_word

  // Program n words of a sector, then wait for completion
  task automatic t_prog(input logic [8:0] s, input int n, input bit rev);
    int i;
    i = 0;
    idle_wait();
    @(posedge clk);
    addr <= {s, 7'h00}; // Sector held on the high lines
    prog_req <= 1'h1;
    set_word(s, 0, n, rev);
    @(posedge clk);
    prog_req <= 1'h0;
    for (int k = 0; k < 20000 && i < n; k++) begin
      @(negedge clk);
      if (word_req && wvalid) begin
        @(posedge clk);
        i++;
        set_word(s, i, n, rev);
      end
    end
    chk("words taken", 16'(n), 16'(i));
    if (i < n) test_done();
    wait_done("program done");
  endtask : t_prog

  // Single read with expected word
  task automatic t_read(input logic [15:0] a, input logic [15:0] e);
    int k;
    idle_wait();
    @(posedge clk);
    addr <= a;
    rd_req <= 1'h1;
    @(posedge clk);
    rd_req <= 1'h0;
    for (k = 0; k < 60 && rd_done !== 1'h1; k++) @(negedge clk);
    chk("read data", e, rd_data);
    if (k == 60) begin
      chk("read done", 16'h0001, 16'h0000);
      test_done();
    end
  endtask : t_read

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("strobes in reset", 16'h0007, {13'h0000, ce_n, oe_n, we_n});
    @(posedge clk);
    rst <= 1'h0;
    t_read(16'h0180, 16'hFFFF);
    t_prog(9'h003, 128, 1'h1);
    t_read(16'h0180, wd(9'h003, 7'h00));
    t_read(16'h01FF, wd(9'h003, 7'h7F));
    t_prog(9'h003, 4, 1'h0);
    t_read(16'h0183, wd(9'h003, 7'h03));
    t_read(16'h0184, 16'hFFFF);
    t_prog(9'h1FF, 1, 1'h0);
    t_read(16'hFF80, wd(9'h1FF, 7'h00));
    t_read(16'h0200, 16'hFFFF);
    idle_wait();
    @(posedge clk);
    ers_req <= 1'h1;
    @(posedge clk);
    ers_req <= 1'h0;
    wait_done("erase done");
    t_read(16'h0183, 16'hFFFF);
    test_done();
  end
endmodule : flash_host_tb_top
